// [rtl/lbc_consts.vh]
// constants for the loopback and per-channel controller block
// assumes an 8-bit microprocessor port and one 25 MHz clock
`ifndef LBC_CONSTS_VH
`define LBC_CONSTS_VH

// ************************************************************
// register offsets
// ************************************************************
`define LBC_ADDR_W 8
`define LBC_OFF_MASTER_DIAG 8'h0a
`define LBC_OFF_UNIT_CFG 8'h0b
`define LBC_OFF_TX_PSC_BASE 8'h10
`define LBC_OFF_RX_PSC_BASE 8'h18
`define LBC_PSC_BASE_MASK 8'hfc

// ************************************************************
// per-controller sub offsets
// ************************************************************
`define LBC_PSC_CFG 2'h0
`define LBC_PSC_STAT 2'h1
`define LBC_PSC_ADDRCTL 2'h2
`define LBC_PSC_DATA 2'h3

// ************************************************************
// field positions
// ************************************************************
`define LBC_BIT_LINE 0
`define LBC_BIT_PAYLOAD 1
`define LBC_BIT_DIAG 2
`define LBC_BIT_RX_DIG 0
`define LBC_BIT_TX_DIG 1
`define LBC_BIT_RX_ES_BYP 2
`define LBC_BIT_RX_BP_CLK 3
`define LBC_BIT_OUT_EN 0
`define LBC_BIT_INDIRECT 1
`define LBC_BIT_BUSY 0
`define LBC_BIT_RD_NWR 7
`define LBC_BIT_LOOP 6

// ************************************************************
// reset values and timing
// ************************************************************
`define LBC_RST_MASTER_DIAG 8'h00
`define LBC_RST_UNIT_CFG 8'h00
`define LBC_RST_PSC_CFG 8'h00
`define LBC_PSC_LOCATIONS 96
`define LBC_PSC_ACCESS_CYCLES 4

`endif

// [rtl/lbc_psc.v]
// one per-channel serial controller: 96 locations, indirect access
// assumes register strobes are one-cycle pulses on mclk
`include "lbc_consts.vh"

module lbc_psc #(
	parameter DEPTH = `LBC_PSC_LOCATIONS,
	parameter ACC_CYCLES = `LBC_PSC_ACCESS_CYCLES
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// register access
	input wire reg_wr,
	input wire [1:0] reg_off,
	input wire [7:0] reg_wdata,
	output wire [7:0] cfg,
	output wire [7:0] addrctl,
	output wire [7:0] data_buf,
	output wire busy,
	// channel lookup
	input wire [6:0] chan,
	output reg [7:0] chan_ctl_r
);

	// ************************************************************
	// state
	// ************************************************************
	reg [7:0] mem [0:DEPTH-1];
	reg [7:0] cfg_r;
	reg [7:0] addrctl_r;
	reg [7:0] data_r;
	reg busy_r;
	reg [2:0] cnt_r;
	wire start;

	assign cfg = cfg_r;
	assign addrctl = addrctl_r;
	assign data_buf = data_r;
	assign busy = busy_r;
	// new access only in indirect mode and only when idle
	assign start = reg_wr && (reg_off == `LBC_PSC_ADDRCTL) && cfg_r[`LBC_BIT_INDIRECT] && !busy_r;

	// ************************************************************
	// configuration and access sequencing
	// ************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			cfg_r <= `LBC_RST_PSC_CFG;
			addrctl_r <= 8'h00;
			data_r <= 8'h00;
			busy_r <= 1'b0;
			cnt_r <= 3'h0;
		end else begin
			if (reg_wr && reg_off == `LBC_PSC_CFG) begin
				cfg_r <= reg_wdata;
			end
			if (reg_wr && reg_off == `LBC_PSC_DATA && !busy_r) begin
				data_r <= reg_wdata;
			end
			if (start) begin
				addrctl_r <= reg_wdata;
				busy_r <= 1'b1;
				cnt_r <= ACC_CYCLES[2:0] - 3'h1;
			end else if (busy_r) begin
				if (cnt_r == 3'h0) begin
					busy_r <= 1'b0;
					if (addrctl_r[`LBC_BIT_RD_NWR] && addrctl_r[6:0] < DEPTH) begin
						data_r <= mem[addrctl_r[6:0]];
					end
				end else begin
					cnt_r <= cnt_r - 3'h1;
				end
			end
		end
	end

	// ************************************************************
	// location memory
	// ************************************************************
	always @(posedge mclk) begin
		if (busy_r && cnt_r == 3'h0 && !addrctl_r[`LBC_BIT_RD_NWR] && addrctl_r[6:0] < DEPTH) begin
			mem[addrctl_r[6:0]] <= data_r;
		end
	end

	// ************************************************************
	// per-channel control output
	// ************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			chan_ctl_r <= 8'h00;
		end else if (cfg_r[`LBC_BIT_OUT_EN] && chan < DEPTH) begin
			chan_ctl_r <= mem[chan];
		end else begin
			chan_ctl_r <= 8'h00;
		end
	end

endmodule

// [rtl/lbc_top.v]
// loopback control and per-channel controllers of an E1/T1 framer
// assumes all stream inputs are single bits synchronous to mclk
//
// Contract
// - line return set: recovered receive data feeds transmit jitter attenuator.
// - line return source is recovery output, or sampled digital input if selected.
// - payload return set: receive elastic store output drives transmitter input.
// - payload return reads the store on transmit timing, follows transmit frame.
// - frame alignment arbitrary with transmit store, else backplane frame pulse.
// - enabled signaling insertion overwrites returned data; receive signaling not realigned.
// - diagnostic return set: transmit attenuator output drives the receiver inputs.
// - analog mode dual-rail to recovery; digital mode single-rail to receive attenuator.
// - selected receive channels replace transmit channels; others pass unchanged; not applied while payload return is set.
// - after reset both controllers are in direct mode; software sets indirect.
// - busy reads high during an access and low once done.
// - busy rises right after the address write and holds until done.
// - line and payload returns may be started at any time.
`include "lbc_consts.vh"

module lbc_top #(
	parameter DEPTH = `LBC_PSC_LOCATIONS,
	parameter ACC_CYCLES = `LBC_PSC_ACCESS_CYCLES
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// microprocessor port
	input wire [7:0] cpu_addr,
	input wire cpu_wr,
	input wire cpu_rd,
	input wire [7:0] cpu_wdata,
	output reg [7:0] cpu_rdata_r,
	// receive line side
	input wire clock_data_recovery_out,
	input wire rx_digital_data_in,
	input wire line_rz_pos,
	input wire line_rz_neg,
	// transmit path
	input wire tx_normal_data,
	input wire backplane_tx_data,
	input wire [6:0] tx_chan,
	input wire tx_sig_insert_en,
	input wire tx_sig_bit_slot,
	input wire tx_sig_bit,
	input wire tx_elastic_bypass,
	input wire backplane_tx_frame_pulse,
	input wire tx_frame_align_int,
	// receive path
	input wire rx_elastic_store_out,
	input wire rx_chan_data,
	input wire [6:0] rx_chan,
	// transmit jitter attenuator outputs
	input wire tja_rz_pos,
	input wire tja_rz_neg,
	input wire tja_nrz,
	// stream outputs
	output reg tx_ja_in_r,
	output reg tx_pcm_in_r,
	output reg cdr_in_pos_r,
	output reg cdr_in_neg_r,
	output reg rx_ja_in_r,
	output reg rx_es_read_tx_clk_r,
	output reg rx_es_frame_align_r,
	// configuration outputs
	output reg rx_digital_select_r,
	output reg tx_digital_select_r,
	output reg rx_elastic_bypass_r,
	output reg rx_backplane_clock_sel_r,
	output reg [7:0] rx_psc_ctl_r
);

	// ************************************************************
	// decode helpers
	// ************************************************************
	function psc_hit;
		input [7:0] a;
		input [7:0] base;
		begin
			psc_hit = ((a & `LBC_PSC_BASE_MASK) == base);
		end
	endfunction

	// ************************************************************
	// registers
	// ************************************************************
	reg [7:0] master_diagnostics_r;
	reg [7:0] unit_cfg_r;
	reg rx_dig_sample_r;
	reg rx_chan_data_r;
	wire line_return_enable;
	wire payload_return_enable;
	wire diag_digital_return_enable;
	wire rx_sel;
	wire tx_wr;
	wire rx_wr;
	wire [7:0] tx_cfg;
	wire [7:0] tx_addrctl;
	wire [7:0] tx_data;
	wire tx_busy;
	wire [7:0] rx_cfg;
	wire [7:0] rx_addrctl;
	wire [7:0] rx_data;
	wire rx_busy;
	wire [7:0] tx_chan_ctl;
	wire [7:0] rx_chan_ctl;
	reg [7:0] rd_nxt;
	reg pcm_nxt;

	assign line_return_enable = master_diagnostics_r[`LBC_BIT_LINE];
	assign payload_return_enable = master_diagnostics_r[`LBC_BIT_PAYLOAD];
	assign diag_digital_return_enable = master_diagnostics_r[`LBC_BIT_DIAG];
	assign rx_sel = unit_cfg_r[`LBC_BIT_RX_DIG];
	assign tx_wr = cpu_wr && psc_hit(cpu_addr, `LBC_OFF_TX_PSC_BASE);
	assign rx_wr = cpu_wr && psc_hit(cpu_addr, `LBC_OFF_RX_PSC_BASE);

	// mode bits are writable at any moment, no gating
	always @(posedge mclk) begin
		if (!rst_n) begin
			master_diagnostics_r <= `LBC_RST_MASTER_DIAG;
			unit_cfg_r <= `LBC_RST_UNIT_CFG;
		end else if (cpu_wr) begin
			if (cpu_addr == `LBC_OFF_MASTER_DIAG) begin
				master_diagnostics_r <= cpu_wdata;
			end
			if (cpu_addr == `LBC_OFF_UNIT_CFG) begin
				unit_cfg_r <= cpu_wdata;
			end
		end
	end

	// ************************************************************
	// per-channel controllers
	// ************************************************************
	lbc_psc #(
		.DEPTH(DEPTH),
		.ACC_CYCLES(ACC_CYCLES)
	) u_tx_per_channel_ctrl (
		.mclk(mclk),
		.rst_n(rst_n),
		.reg_wr(tx_wr),
		.reg_off(cpu_addr[1:0]),
		.reg_wdata(cpu_wdata),
		.cfg(tx_cfg),
		.addrctl(tx_addrctl),
		.data_buf(tx_data),
		.busy(tx_busy),
		.chan(tx_chan),
		.chan_ctl_r(tx_chan_ctl)
	);

	lbc_psc #(
		.DEPTH(DEPTH),
		.ACC_CYCLES(ACC_CYCLES)
	) u_rx_per_channel_ctrl (
		.mclk(mclk),
		.rst_n(rst_n),
		.reg_wr(rx_wr),
		.reg_off(cpu_addr[1:0]),
		.reg_wdata(cpu_wdata),
		.cfg(rx_cfg),
		.addrctl(rx_addrctl),
		.data_buf(rx_data),
		.busy(rx_busy),
		.chan(rx_chan),
		.chan_ctl_r(rx_chan_ctl)
	);

	// ************************************************************
	// register read
	// ************************************************************
	always @* begin
		rd_nxt = 8'h00;
		if (cpu_addr == `LBC_OFF_MASTER_DIAG) begin
			rd_nxt = master_diagnostics_r;
		end else if (cpu_addr == `LBC_OFF_UNIT_CFG) begin
			rd_nxt = unit_cfg_r;
		end else if (psc_hit(cpu_addr, `LBC_OFF_TX_PSC_BASE)) begin
			case (cpu_addr[1:0])
				`LBC_PSC_CFG: rd_nxt = tx_cfg;
				`LBC_PSC_STAT: rd_nxt = {7'h00, tx_busy};
				`LBC_PSC_ADDRCTL: rd_nxt = tx_addrctl;
				default: rd_nxt = tx_data;
			endcase
		end else if (psc_hit(cpu_addr, `LBC_OFF_RX_PSC_BASE)) begin
			case (cpu_addr[1:0])
				`LBC_PSC_CFG: rd_nxt = rx_cfg;
				`LBC_PSC_STAT: rd_nxt = {7'h00, rx_busy};
				`LBC_PSC_ADDRCTL: rd_nxt = rx_addrctl;
				default: rd_nxt = rx_data;
			endcase
		end
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			cpu_rdata_r <= 8'h00;
		end else if (cpu_rd) begin
			cpu_rdata_r <= rd_nxt;
		end
	end

	// ************************************************************
	// transmit payload path
	// ************************************************************
	always @* begin
		pcm_nxt = payload_return_enable ? rx_elastic_store_out : backplane_tx_data;
		if (!payload_return_enable && tx_chan_ctl[`LBC_BIT_LOOP]) begin
			pcm_nxt = rx_chan_data_r;
		end
		if (tx_sig_insert_en && tx_sig_bit_slot) begin
			pcm_nxt = tx_sig_bit;
		end
	end

	// ************************************************************
	// stream multiplexers
	// ************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			rx_dig_sample_r <= 1'b0;
			rx_chan_data_r <= 1'b0;
			tx_ja_in_r <= 1'b0;
			tx_pcm_in_r <= 1'b0;
			cdr_in_pos_r <= 1'b0;
			cdr_in_neg_r <= 1'b0;
			rx_ja_in_r <= 1'b0;
			rx_es_read_tx_clk_r <= 1'b0;
			rx_es_frame_align_r <= 1'b0;
		end else begin
			rx_dig_sample_r <= rx_digital_data_in;
			rx_chan_data_r <= rx_chan_data;
			if (line_return_enable) begin
				tx_ja_in_r <= rx_sel ? rx_dig_sample_r : clock_data_recovery_out;
			end else begin
				tx_ja_in_r <= tx_normal_data;
			end
			tx_pcm_in_r <= pcm_nxt;
			rx_es_read_tx_clk_r <= payload_return_enable;
			if (payload_return_enable) begin
				rx_es_frame_align_r <= tx_elastic_bypass ? backplane_tx_frame_pulse
					: tx_frame_align_int;
			end else begin
				rx_es_frame_align_r <= 1'b0;
			end
			if (diag_digital_return_enable && !rx_sel) begin
				cdr_in_pos_r <= tja_rz_pos;
				cdr_in_neg_r <= tja_rz_neg;
			end else begin
				cdr_in_pos_r <= line_rz_pos;
				cdr_in_neg_r <= line_rz_neg;
			end
			if (diag_digital_return_enable && rx_sel) begin
				rx_ja_in_r <= tja_nrz;
			end else begin
				rx_ja_in_r <= rx_digital_data_in;
			end
		end
	end

	// ************************************************************
	// configuration outputs
	// ************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			rx_digital_select_r <= 1'b0;
			tx_digital_select_r <= 1'b0;
			rx_elastic_bypass_r <= 1'b0;
			rx_backplane_clock_sel_r <= 1'b0;
			rx_psc_ctl_r <= 8'h00;
		end else begin
			rx_digital_select_r <= unit_cfg_r[`LBC_BIT_RX_DIG];
			tx_digital_select_r <= unit_cfg_r[`LBC_BIT_TX_DIG];
			rx_elastic_bypass_r <= unit_cfg_r[`LBC_BIT_RX_ES_BYP];
			rx_backplane_clock_sel_r <= unit_cfg_r[`LBC_BIT_RX_BP_CLK];
			rx_psc_ctl_r <= rx_chan_ctl;
		end
	end

endmodule

// [dv/lbc_top_props.sv]
// assertions on the lbc_top stream and register ports
// assumes the bind at the foot attaches it to every lbc_top
module lbc_top_props (
	// clock, reset, register writes
	input logic mclk, rst_n, cpu_wr,
	input logic [7:0] cpu_addr, cpu_wdata,
	// stream inputs
	input logic clock_data_recovery_out, rx_digital_data_in, tja_rz_pos, tja_rz_neg, tja_nrz,
	input logic tx_sig_insert_en, tx_sig_bit_slot, tx_sig_bit, rx_elastic_store_out,
	input logic tx_elastic_bypass, backplane_tx_frame_pulse, tx_frame_align_int,
	// stream outputs
	input logic tx_ja_in_r, tx_pcm_in_r, cdr_in_pos_r, cdr_in_neg_r, rx_ja_in_r,
	input logic rx_es_read_tx_clk_r, rx_es_frame_align_r, rx_digital_select_r
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] dg_r;
	always @(posedge mclk)
		if (!rst_n) dg_r <= 3'h0;
		else if (cpu_wr && cpu_addr == 8'h0a) dg_r <= cpu_wdata[2:0];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_LINE_REC: assert property ($past(dg_r[0]) && !rx_digital_select_r
		|-> tx_ja_in_r == $past(clock_data_recovery_out)) else $error("line return bad");
	AST_LINE_DIG: assert property ($past(dg_r[0]) && rx_digital_select_r
		|-> tx_ja_in_r == $past(rx_digital_data_in, 2)) else $error("line digital bad");
	AST_PAYLOAD: assert property (dg_r[1] && !(tx_sig_insert_en && tx_sig_bit_slot)
		|=> tx_pcm_in_r == $past(rx_elastic_store_out)) else $error("payload bad");
	AST_SIG_OVR: assert property (tx_sig_insert_en && tx_sig_bit_slot
		|=> tx_pcm_in_r == $past(tx_sig_bit)) else $error("signaling bad");
	AST_TX_TIMING: assert property (rx_es_read_tx_clk_r == $past(dg_r[1]))
		else $error("store timing bad");
	AST_ALIGN: assert property (1'b1 |=> rx_es_frame_align_r == ($past(dg_r[1]) &&
		($past(tx_elastic_bypass) ? $past(backplane_tx_frame_pulse) : $past(tx_frame_align_int))))
		else $error("frame align bad");
	AST_DIAG_RZ: assert property ($past(dg_r[2]) && !rx_digital_select_r
		|-> {cdr_in_pos_r, cdr_in_neg_r} == {$past(tja_rz_pos), $past(tja_rz_neg)})
		else $error("diag rz bad");
	AST_DIAG_NRZ: assert property ($past(dg_r[2]) && rx_digital_select_r
		|-> rx_ja_in_r == $past(tja_nrz)) else $error("diag nrz bad");
endmodule
bind lbc_top lbc_top_props lbc_top_props_i (.*);

// [dv/lbc_partner.sv]
// far-side stream source: line, backplane and attenuator bits
// assumes mclk from the bench; bits move on the falling edge
module lbc_partner (
	// clock
	input logic mclk,
	// stream bits
	output logic [15:0] bits
);
	timeunit 1ns;
	timeprecision 1ps;
	initial bits = 16'h1ace;
	always @(negedge mclk)
		bits <= {bits[14:0], bits[15] ^ bits[13] ^ bits[12] ^ bits[10]};
endmodule

// [dv/test_lbc_top.sv]
// bench for lbc_top: register tasks, indirect access, stream checks
// assumes lbc_partner drives the far-side streams
module test_lbc_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst_n = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, tx_sig_insert_en = 1'b0;
	logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, cpu_rdata_r, rx_psc_ctl_r;
	logic [6:0] tx_chan = 7'h00, rx_chan = 7'h00;
	logic [15:0] b;
	logic tja_nrz, tja_rz_neg, tja_rz_pos, rx_chan_data, rx_elastic_store_out;
	logic tx_frame_align_int, backplane_tx_frame_pulse, tx_elastic_bypass, tx_sig_bit;
	logic tx_sig_bit_slot, backplane_tx_data, tx_normal_data, line_rz_neg, line_rz_pos;
	logic rx_digital_data_in, clock_data_recovery_out, rc1, rc2, bp1;
	logic tx_ja_in_r, tx_pcm_in_r, cdr_in_pos_r, cdr_in_neg_r, rx_ja_in_r, rx_es_read_tx_clk_r;
	logic rx_es_frame_align_r, rx_digital_select_r, tx_digital_select_r;
	logic rx_elastic_bypass_r, rx_backplane_clock_sel_r;
	logic [7:0] ra [9] = '{8'h0a, 8'h0b, 8'h10, 8'h11, 8'h12, 8'h13, 8'h18, 8'h19, 8'h55};
	int num_errors = 0, checks = 0, n;
	assign {tja_nrz, tja_rz_neg, tja_rz_pos, rx_chan_data, rx_elastic_store_out,
		tx_frame_align_int, backplane_tx_frame_pulse, tx_elastic_bypass, tx_sig_bit,
		tx_sig_bit_slot, backplane_tx_data, tx_normal_data, line_rz_neg, line_rz_pos,
		rx_digital_data_in, clock_data_recovery_out} = b;
	lbc_partner lbc_partner_i (.mclk(mclk), .bits(b));
	lbc_top lbc_top_i (.*);
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		rc1 <= rx_chan_data;
		rc2 <= rc1;
		bp1 <= backplane_tx_data;
	end
	// ****************************************
	// access tasks
	// ****************************************
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(negedge mclk);
		cpu_wr = w;
		cpu_rd = !w;
		cpu_addr = a;
		cpu_wdata = d;
		@(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, exp);
		acc(1'b0, a, 8'h00);
		chk(cpu_rdata_r, exp);
	endtask
	task automatic idle(input int k);
		repeat (k) begin
			@(negedge mclk);
			cpu_wr = 1'b0;
			cpu_rd = 1'b0;
		end
	endtask
	task automatic poll(input logic [7:0] base);
		n = 0;
		acc(1'b0, base + 8'h01, 8'h00);
		while (cpu_rdata_r[0] === 1'b1 && n < 20) begin
			n++;
			acc(1'b0, base + 8'h01, 8'h00);
		end
	endtask
	task automatic iwr(input logic [7:0] base, input logic [6:0] ch, input logic [7:0] d);
		acc(1'b1, base + 8'h03, d);
		acc(1'b1, base + 8'h02, {1'b0, ch});
		poll(base);
		chk(8'(n), 8'h04);
	endtask
	task automatic ird(input logic [7:0] base, input logic [6:0] ch, input logic [7:0] e);
		acc(1'b1, base + 8'h02, {1'b1, ch});
		poll(base);
		rd(base + 8'h03, e);
	endtask
	task automatic stream(input logic lp);
		idle(4);
		repeat (4) begin
			@(posedge mclk);
			#1;
			chk({7'h0, tx_pcm_in_r}, {7'h0, lp ? rc2 : bp1});
		end
		chk(rx_psc_ctl_r, lp ? 8'h5a : 8'h00);
	endtask
	task automatic wrap_up;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		#400000;
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge mclk);
		@(negedge mclk) rst_n = 1'b1;
		foreach (ra[i]) rd(ra[i], 8'h00);
		acc(1'b1, 8'h12, 8'h85);
		rd(8'h11, 8'h00);
		acc(1'b1, 8'h10, 8'h02);
		acc(1'b1, 8'h18, 8'h02);
		for (int c = 0; c < 96; c++) begin
			iwr(8'h10, c[6:0], c == 5 ? 8'h40 : 8'h00);
			iwr(8'h18, c[6:0], c == 7 ? 8'h5a : 8'h00);
		end
		acc(1'b1, 8'h10, 8'h03);
		acc(1'b1, 8'h18, 8'h03);
		ird(8'h10, 7'd5, 8'h40);
		ird(8'h18, 7'd7, 8'h5a);
		ird(8'h18, 7'd100, 8'h5a);
		acc(1'b1, 8'h13, 8'h77);
		acc(1'b1, 8'h12, 8'h09);
		acc(1'b1, 8'h12, 8'h0a);
		acc(1'b1, 8'h13, 8'h11);
		rd(8'h11, 8'h01);
		poll(8'h10);
		ird(8'h10, 7'd9, 8'h77);
		ird(8'h10, 7'd10, 8'h00);
		acc(1'b1, 8'h0b, 8'h0a);
		rd(8'h0b, 8'h0a);
		chk({4'h0, rx_backplane_clock_sel_r, rx_elastic_bypass_r, tx_digital_select_r,
			rx_digital_select_r}, 8'h0a);
		acc(1'b1, 8'h0b, 8'h04);
		rd(8'h0b, 8'h04);
		chk({4'h0, rx_backplane_clock_sel_r, rx_elastic_bypass_r, tx_digital_select_r,
			rx_digital_select_r}, 8'h04);
		@(negedge mclk);
		tx_chan = 7'd5;
		rx_chan = 7'd7;
		stream(1'b1);
		@(negedge mclk);
		tx_chan = 7'd6;
		rx_chan = 7'd100;
		stream(1'b0);
		@(negedge mclk) tx_sig_insert_en = 1'b1;
		for (int s = 0; s < 2; s++)
			for (int m = 0; m < 3; m++) begin
				acc(1'b1, 8'h0b, s ? 8'h03 : 8'h00);
				acc(1'b1, 8'h0a, 8'(1 << m));
				rd(8'h0a, 8'(1 << m));
				idle(6);
				chk({7'h0, rx_es_read_tx_clk_r}, {7'h0, m == 1});
			end
		acc(1'b1, 8'h0a, 8'h00);
		idle(2);
		wrap_up();
	end
endmodule
